// ==== design/ttu_top.v ====
// Three 16-bit timers with a classic Wishbone register slave
// Function
// - 16-bit count, incremented, always readable/writable
// - Match returns count to zero same clock
// - Single compare: output low one clock
// - Dual compare: output high A, low B
// - Timer serviced every fourth clock
// - Output responds within six clocks
// - Register access adds one wait state
// - Alternate compare switches A and B
// - Continuous run or halt at max
// - External clock counts synchronised rising edges
// - Prescale selects quarter clock or timer 2
// - Retrigger zero: pin level gates counting
// - Retrigger one: rising edge clears count
// - Disabled timer ignores pins; auto-clear enable
// - Enable written only with mask bit
// - Interrupt request on every terminal count
// - Max count status set every match
// - Compare-in-use readonly, cleared without alternate
// - Timer 2 has reduced hardwired features
// - Count write takes effect immediately
// - Reset only on exact equality, wraps
// - Reset clears enables, selects register A
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ns
`include "ttu_regs.vh"
module ttu_top #(
  parameter NTIMER = 3                // Number of timers, the last one is pinless
) (
  input  wire        clk_i,           // Processor clock, 125 MHz
  input  wire        rst_i,           // Synchronous reset, active high
  input  wire        cyc_i,           // Wishbone cycle
  input  wire        stb_i,           // Wishbone strobe
  input  wire        we_i,            // Wishbone write enable
  input  wire [9:0]  adr_i,           // Wishbone byte address
  input  wire [3:0]  sel_i,           // Wishbone byte selects
  input  wire [31:0] dat_i,           // Wishbone write data
  output wire [31:0] dat_o,           // Wishbone read data
  output wire        ack_o,           // Wishbone acknowledge
  input  wire [1:0]  tin_i,           // Timer 0/1 input pins
  output wire [1:0]  tout_o,          // Timer 0/1 output pins
  output wire [2:0]  irq_o            // Terminal count requests, one-cycle pulses
);

  // ********************************************************************
  // Declarations
  // ********************************************************************
  reg  [1:0]            phase_reg;    // Service phase
  reg                   wait_reg;     // Inserted wait state done
  reg                   ack_reg;
  reg  [31:0]           dat_reg;
  reg  [15:0]           rd_data;      // Combined read word
  wire [NTIMER-1:0]     rd_hit;
  wire [NTIMER*16-1:0]  rd_word;
  wire [NTIMER-1:0]     tc_w;         // Terminal count of each timer
  wire [NTIMER-1:0]     irq_w;
  wire [7:0]            idx;          // Register index
  wire                  svc_tick;
  wire                  wr_go;
  wire                  t2_tc;
  integer               k;

  // Byte-lane merge of a write into a 16-bit register
  function [15:0] ttu_merge;
    input [15:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel_v;
    begin
      ttu_merge = {(sel_v[1] ? new_v[15:8] : old_v[15:8]),
                   (sel_v[0] ? new_v[7:0]  : old_v[7:0])};
    end
  endfunction

  // ********************************************************************
  // Service phase
  // ********************************************************************

  // All timers share one free-running phase, so every timer is
  // serviced in the same slot and the timer 2 prescale event lines
  // up with the slot in which the other timers sample it.
  // quarter rate: one service slot in four clocks
  always @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  assign svc_tick = (phase_reg == `TTU_SVC_LAST);
  assign t2_tc    = tc_w[NTIMER-1];

  // ********************************************************************
  // Wishbone slave
  // ********************************************************************
  // A request is seen at the first edge and the wait state passes.
  // Ack rises at the second edge and stands for one cycle. The master
  // samples ack at the third edge, where a write lands; read data was
  // already captured one edge earlier. Ack then drops whatever the
  // master does, so a held request cannot be answered twice in a row.
  assign idx   = adr_i[9:2];
  // Writes land on the edge where the master samples ack
  assign wr_go = cyc_i & stb_i & we_i & ack_reg;

  // Read data from whichever timer claims the index
  // An unmapped index claims nothing and reads as zero
  always @* begin
    rd_data = 16'h0000;
    for (k = 0; k < NTIMER; k = k + 1) begin
      if (rd_hit[k]) begin
        rd_data = rd_data | rd_word[k*16 +: 16];
      end
    end
  end

  // one wait: ack in the third cycle of the request
  always @(posedge clk_i) begin
    if (rst_i) begin
      wait_reg <= 1'b0;
      ack_reg  <= 1'b0;
      dat_reg  <= 32'h00000000;
    end else if (ack_reg) begin
      wait_reg <= 1'b0;
      ack_reg  <= 1'b0;
    end else if (cyc_i && stb_i) begin
      if (!wait_reg) begin
        wait_reg <= 1'b1;
      end else begin
        ack_reg <= 1'b1;
        dat_reg <= {16'h0000, rd_data};
      end
    end else begin
      wait_reg <= 1'b0;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;
  assign irq_o = irq_w;

  // ********************************************************************
  // Timer channels
  // ********************************************************************
  genvar i;
  generate
    for (i = 0; i < NTIMER; i = i + 1) begin : g_tmr
      // reduced timer: last timer has no pins, no register B
      localparam HAS_PIN = (i < NTIMER - 1);
      localparam integer BASE_I = `TTU_T0_COUNT + i * `TTU_STRIDE;
      localparam [7:0] BASE = BASE_I[7:0];

      reg  [15:0] cnt_reg;
      reg  [15:0] cmpa_reg;
      reg  [15:0] cmpb_reg;
      reg         en_reg;
      reg         int_reg;
      reg         mc_reg;
      reg         riu_reg;
      reg         alt_reg;
      reg         continuous_run_reg;
      reg         ext_reg;
      reg         pre_reg;
      reg         rtg_reg;
      reg         pend_reg;           // Latched external or prescale event
      reg         start_reg;          // Retrigger mode started
      reg         irq_reg;
      wire        pin_lvl;
      wire        pin_rise;
      wire        sel_cnt;
      wire        sel_cmpa;
      wire        sel_cmpb;
      wire        sel_ctl;
      wire [15:0] ctl_word;
      wire [15:0] ctl_wr;
      wire [15:0] cmp_act;
      wire [15:0] cnt_inc;
      wire        pend_set;
      wire        evt_raw;
      wire        gate_ok;
      wire        retrig;
      wire        inc;
      wire        tc;
      wire        stop;

      if (HAS_PIN) begin : g_pin
        ttu_sync u_sync (
          .clk_i   (clk_i),
          .rst_i   (rst_i),
          .pin_i   (tin_i[i]),
          .level_o (pin_lvl),
          .rise_o  (pin_rise)
        );
        // Output pin sits two flops behind the terminal count, which
        // places the single-compare pulse in the second cycle after it.
        // pulse output: and level output, short pipeline
        ttu_outpin u_out (
          .clk_i  (clk_i),
          .rst_i  (rst_i),
          .tc_i   (tc),
          .alt_i  (alt_reg),
          .riu_i  (riu_reg),
          .tout_o (tout_o[i])
        );
      end else begin : g_nopin
        // Pinless timer: level reads high so its gate is always open,
        // and no edge ever arrives to retrigger or clock it
        assign pin_lvl  = 1'b1;
        assign pin_rise = 1'b0;
      end

      // Address decode of this timer's registers
      // The pinless timer has no register B; its slot stays unmapped
      assign sel_cnt  = (idx == BASE + `TTU_OFS_COUNT);
      assign sel_cmpa = (idx == BASE + `TTU_OFS_CMPA);
      assign sel_cmpb = HAS_PIN && (idx == BASE + `TTU_OFS_CMPB);
      assign sel_ctl  = (idx == BASE + `TTU_OFS_CTL);

      assign ctl_word = {en_reg, 1'b0, int_reg, riu_reg, 6'h00,
                         mc_reg, rtg_reg, pre_reg, ext_reg, alt_reg, continuous_run_reg};
      assign ctl_wr   = ttu_merge(ctl_word, dat_i, sel_i);

      assign rd_hit[i] = sel_cnt | sel_cmpa | sel_cmpb | sel_ctl;
      assign rd_word[i*16 +: 16] = sel_cnt  ? cnt_reg  :
                                   sel_cmpa ? cmpa_reg :
                                   sel_cmpb ? cmpb_reg : ctl_word;

      // active compare: B only while in use
      assign cmp_act = riu_reg ? cmpb_reg : cmpa_reg;
      assign cnt_inc = cnt_reg + 16'h0001;

      // prescale source: timer 2 events, external edges
      // disabled ignores pins: nothing latched while disabled
      assign pend_set = en_reg & (ext_reg ? pin_rise : (pre_reg & t2_tc));
      // quarter rate: events only in the service slot
      assign evt_raw  = svc_tick & ((ext_reg | pre_reg) ? pend_reg : 1'b1);
      // External clocking ignores the pin level; gating is internal only
      // level gate: and start on first edge
      assign gate_ok  = ext_reg ? 1'b1 : (rtg_reg ? start_reg : pin_lvl);
      // retrigger edge: clears count next clock
      assign retrig   = en_reg & ~ext_reg & rtg_reg & pin_rise;
      assign inc      = en_reg & evt_raw & gate_ok & ~retrig;
      // match to zero: compare value never stored
      // exact equality: no greater-than test, count wraps
      assign tc       = inc & (cnt_inc == cmp_act);
      // halt rule: dual mode halts after B
      assign stop     = tc & ~continuous_run_reg & (~alt_reg | riu_reg);

      assign tc_w[i]  = tc;
      assign irq_w[i] = irq_reg;

      // Count register
      // Priority: software write, then clear on match or retrigger,
      // then increment. A write in the slot of a match therefore wins
      // over the clear, though the match still sets its status and request; software owns the count.
      always @(posedge clk_i) begin
        if (rst_i) begin
          cnt_reg <= `TTU_CNT_RST;
        end else if (wr_go && sel_cnt) begin
          // immediate write: overrides the running count
          cnt_reg <= ttu_merge(cnt_reg, dat_i, sel_i);
        end else if (retrig || tc) begin
          cnt_reg <= 16'h0000;
        end else if (inc) begin
          // count up: one per qualified event
          cnt_reg <= cnt_inc;
        end
      end

      // Compare registers
      // A compare value of zero lets the count run the full 16-bit
      // range, since the match is taken on the wrapped next value
      always @(posedge clk_i) begin
        if (rst_i) begin
          cmpa_reg <= `TTU_CMP_RST;
          cmpb_reg <= `TTU_CMP_RST;
        end else begin
          if (wr_go && sel_cmpa) begin
            cmpa_reg <= ttu_merge(cmpa_reg, dat_i, sel_i);
          end
          if (wr_go && sel_cmpb) begin
            cmpb_reg <= ttu_merge(cmpb_reg, dat_i, sel_i);
          end
        end
      end

      // Control fields, status and event latches
      always @(posedge clk_i) begin
        if (rst_i) begin
          // reset state: disabled, register A selected
          en_reg    <= 1'b0;
          int_reg   <= 1'b0;
          mc_reg    <= 1'b0;
          riu_reg   <= 1'b0;
          alt_reg   <= 1'b0;
          continuous_run_reg  <= 1'b0;
          ext_reg   <= 1'b0;
          pre_reg   <= 1'b0;
          rtg_reg   <= 1'b0;
          pend_reg  <= 1'b0;
          start_reg <= 1'b0;
          irq_reg   <= 1'b0;
        end else begin
          // An event that lands outside the slot waits here until the
          // next slot; the latch drops while the timer is disabled so a
          // stale event cannot count after the next enable.
          // spacing: one latch suffices for edges four clocks apart
          pend_reg  <= pend_set | (pend_reg & ~svc_tick & en_reg);
          // start flag: set by the first edge
          start_reg <= en_reg & (start_reg | retrig);
          // interrupt request: one pulse per terminal count
          irq_reg   <= tc & int_reg;
          // max count: hardware set wins over software write
          mc_reg    <= tc | ((wr_go && sel_ctl) ? ctl_wr[`TTU_CTL_MC] : mc_reg);
          // compare in use: toggles on match, cleared without alternate
          if (!alt_reg) begin
            riu_reg <= 1'b0;
          end else if (tc) begin
            riu_reg <= ~riu_reg;
          end
          // A masked write in the same cycle as the final match wins, so
          // software can restart a timer that is just halting.
          // masked enable: written only with mask set
          if (wr_go && sel_ctl && sel_i[1] && dat_i[`TTU_CTL_INH]) begin
            en_reg <= ctl_wr[`TTU_CTL_EN];
          end else if (stop) begin
            // auto clear: enable drops at final count
            en_reg <= 1'b0;
          end
          if (wr_go && sel_ctl) begin
            int_reg  <= ctl_wr[`TTU_CTL_INT];
            continuous_run_reg <= ctl_wr[`TTU_CTL_CONTINUOUS_RUN];
            // hardwired zero: mode bits fixed on the pinless timer
            alt_reg  <= HAS_PIN ? ctl_wr[`TTU_CTL_ALT] : 1'b0;
            ext_reg  <= HAS_PIN ? ctl_wr[`TTU_CTL_EXT] : 1'b0;
            pre_reg  <= HAS_PIN ? ctl_wr[`TTU_CTL_PRE] : 1'b0;
            rtg_reg  <= HAS_PIN ? ctl_wr[`TTU_CTL_RTG] : 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule // ttu_top

// ==== design/ttu_regs.vh ====
// Register indices, field positions, reset values and timing counts of the timer unit
`ifndef TTU_REGS_VH
`define TTU_REGS_VH

// ********************************************************************
// Register indices (byte address on the bus is four times the index)
// ********************************************************************
`define TTU_T0_COUNT      8'h50
`define TTU_T0_COMPARE_A  8'h52
`define TTU_T0_COMPARE_B  8'h54
`define TTU_T0_CONTROL    8'h56
`define TTU_T1_COUNT      8'h58
`define TTU_T1_COMPARE_A  8'h5a
`define TTU_T1_COMPARE_B  8'h5c
`define TTU_T1_CONTROL    8'h5e
`define TTU_T2_COUNT      8'h60
`define TTU_T2_COMPARE_A  8'h62
`define TTU_T2_CONTROL    8'h66
// Distance between two timers and register offsets inside one timer
`define TTU_STRIDE        8'h08
`define TTU_OFS_COUNT     8'h00
`define TTU_OFS_CMPA      8'h02
`define TTU_OFS_CMPB      8'h04
`define TTU_OFS_CTL       8'h06

// ********************************************************************
// Control word field positions
// ********************************************************************
`define TTU_CTL_EN        15
`define TTU_CTL_INH       14
`define TTU_CTL_INT       13
`define TTU_CTL_RIU       12
`define TTU_CTL_MC        5
`define TTU_CTL_RTG       4
`define TTU_CTL_PRE       3
`define TTU_CTL_EXT       2
`define TTU_CTL_ALT       1
`define TTU_CTL_CONTINUOUS_RUN      0

// ********************************************************************
// Reset values and timing counts
// ********************************************************************
`define TTU_CNT_RST       16'h0000
`define TTU_CMP_RST       16'h0000
`define TTU_SVC_LAST      2'h3
`define TTU_BUS_WAITS     1

`endif

// ==== design/ttu_sync.v ====
// Two-flop synchroniser for a timer input pin with rising-edge detect
`timescale 1ns/1ns
module ttu_sync (
  input  wire clk_i,    // Processor clock
  input  wire rst_i,    // Synchronous reset, active high
  input  wire pin_i,    // Asynchronous pin
  output wire level_o,  // Synchronised level
  output wire rise_o    // One-cycle pulse on low-to-high
);

  reg meta_reg;
  reg sync_reg;
  reg last_reg;

  // Synchroniser chain; only sync_reg reads meta_reg
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level_o = sync_reg;
  assign rise_o  = sync_reg & ~last_reg;

endmodule // ttu_sync

// ==== design/ttu_outpin.v ====
// Timer output pin driver: delayed low pulse or compare-in-use level
`timescale 1ns/1ns
module ttu_outpin (
  input  wire clk_i,        // Processor clock
  input  wire rst_i,        // Synchronous reset, active high
  input  wire tc_i,         // Terminal count pulse
  input  wire alt_i,        // Alternate compare mode
  input  wire riu_i,        // Compare in use, 1 means B
  output wire tout_o        // Timer output pin
);

  reg tc_d1_reg;
  reg out_reg;

  // Pulse sits low in the second cycle after the terminal count
  always @(posedge clk_i) begin
    if (rst_i) begin
      tc_d1_reg <= 1'b0;
      out_reg   <= 1'b1;
    end else begin
      tc_d1_reg <= tc_i;
      out_reg   <= alt_i ? ~riu_i : ~tc_d1_reg;
    end
  end

  assign tout_o = out_reg;

endmodule // ttu_outpin

// ==== verif/ttu_props.sv ====
// Checker of bus handshake and pin timing for the timer unit
`timescale 1ns/1ns
module ttu_props #(
  parameter NTIMER = 3          // Timer count
) (
  input wire        clk_i,      // Clock
  input wire        rst_i,      // Reset
  input wire        cyc_i,      // Cycle
  input wire        stb_i,      // Strobe
  input wire        we_i,       // Write
  input wire [9:0]  adr_i,      // Address
  input wire [3:0]  sel_i,      // Selects
  input wire [31:0] dat_i,      // Write data
  input wire [31:0] dat_o,      // Read data
  input wire        ack_o,      // Acknowledge
  input wire [1:0]  tin_i,      // Input pins
  input wire [1:0]  tout_o,     // Output pins
  input wire [2:0]  irq_o       // Requests
);
  // ****************************************
  // Timer 0 mode shadow and properties
  // ****************************************
  reg  alt0_reg;                // Alternate mode of timer 0
  wire req = cyc_i && stb_i;    // Bus request
  // Track alternate bit written to timer 0 control
  always @(posedge clk_i) begin
    if (rst_i)
      alt0_reg <= 1'b0;
    else if (ack_o && we_i && adr_i[9:2] == 8'h56 && sel_i[0])
      alt0_reg <= dat_i[1];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_wait: assert property (
    $rose(req) |-> !ack_o ##1 !ack_o ##1 ack_o) else $error("ack latency wrong");
  a_ack_pulse: assert property (
    ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_ack_cause: assert property (
    ack_o |-> req && $past(req)) else $error("ack without request");
  a_dat_width: assert property (
    dat_o[31:16] == 16'h0000) else $error("read data upper half set");
  a_irq0_gap: assert property (
    irq_o[0] |=> !irq_o[0] [*3]) else $error("timer 0 requests too close");
  a_irq2_gap: assert property (
    irq_o[2] |=> !irq_o[2] [*3]) else $error("timer 2 requests too close");
  a_tout_pulse: assert property (
    irq_o[0] && !alt0_reg |=> !tout_o[0] ##1 tout_o[0]) else $error("output pulse misplaced");
  a_tout_short: assert property (
    !alt0_reg && !$past(alt0_reg) && !tout_o[0] |=> tout_o[0]) else $error("output low too long");
  a_reset_out: assert property (
    $fell(rst_i) |-> tout_o == 2'b11 && irq_o == 3'h0 && !ack_o) else $error("bad reset state");
endmodule // ttu_props

bind ttu_top ttu_props #(.NTIMER(NTIMER)) ttu_props_i (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .tin_i(tin_i), .tout_o(tout_o), .irq_o(irq_o));

// ==== verif/ttu_pin_src.sv ====
// Event source model driving the timer input pins
`timescale 1ns/1ns
module ttu_pin_src (
  input  wire       clk_i,    // Clock
  input  wire       rst_i,    // Reset
  input  wire [1:0] hold_i,   // Static pin level
  input  wire [1:0] burst_i,  // Edges every four clocks
  output wire [1:0] tin_o     // Timer input pins
);
  // ****************************************
  // Burst generator
  // ****************************************
  reg [1:0] ph0_reg;          // Phase of pin 0
  reg [1:0] ph1_reg;          // Phase of pin 1
  always @(posedge clk_i) begin
    ph0_reg <= (rst_i || !burst_i[0]) ? 2'h0 : ph0_reg + 2'h1;
    ph1_reg <= (rst_i || !burst_i[1]) ? 2'h0 : ph1_reg + 2'h1;
  end
  // Pin high for the first half of each period
  assign tin_o = hold_i | (burst_i & {~ph1_reg[1], ~ph0_reg[1]});
endmodule // ttu_pin_src

// ==== verif/ttu_top_tb.sv ====
// Self-checking testbench of the timer unit
`timescale 1ns/1ns
module ttu_top_tb;
  reg         clk_i, rst_i, cyc_i, stb_i, we_i;
  reg  [9:0]  adr_i;
  reg  [3:0]  sel_i;
  reg  [31:0] dat_i;
  reg  [1:0]  hold, burst;
  reg  [15:0] rd;
  wire [31:0] dat_o;
  wire        ack_o;
  wire [1:0]  tin_i, tout_o;
  wire [2:0]  irq_o;
  int         error_cnt, samples_checked, gap;
  always #4 clk_i = ~clk_i;
  ttu_top #(.NTIMER(3)) ttu_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .tin_i(tin_i), .tout_o(tout_o), .irq_o(irq_o));
  ttu_pin_src ttu_pin_src_i (.clk_i(clk_i), .rst_i(rst_i), .hold_i(hold),
    .burst_i(burst), .tin_o(tin_i));
  // ****************************************
  // Tasks
  // ****************************************
  task report_and_stop;
    $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One classic Wishbone cycle, entered right after a rising edge
  task wb(input logic w, input logic [7:0] idx, input logic [15:0] d, input logic [1:0] s);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= {2'b00, s};
    dat_i <= {16'h0000, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20) begin
      check("ack", 16'h0001, 16'h0000);
      report_and_stop;
    end
    rd = dat_o[15:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task wr(input logic [7:0] idx, input logic [15:0] d);
    wb(1'b1, idx, d, 2'h3);
  endtask
  task rchk(input string nm, input logic [7:0] idx, input logic [15:0] exp);
    wb(1'b0, idx, 16'h0000, 2'h3);
    check(nm, exp, rd);
  endtask
  // Count edges until a request pulse of timer b is seen
  task wirq(input int b, output int n);
    n = 1;
    @(posedge clk_i);
    while (irq_o[b] !== 1'b1 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 300) begin
      check("irq", 16'h0001, 16'h0000);
      report_and_stop;
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {clk_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, hold, burst} = '0;
    rst_i = 1'b1;
    error_cnt = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rchk("t0 control", 8'h56, 16'h0000);
    rchk("t1 count", 8'h58, 16'h0000);
    wr(8'h50, 16'h1234);
    wb(1'b1, 8'h50, 16'habcd, 2'h1);
    rchk("t0 count", 8'h50, 16'h12cd);
    wr(8'h64, 16'hffff);
    rchk("unmapped", 8'h64, 16'h0000);
    wr(8'h56, 16'h8001);
    rchk("t0 control", 8'h56, 16'h0001);
    $display("Done registers");
    hold <= 2'b01;
    wr(8'h52, 16'h0005);
    wr(8'h50, 16'h0000);
    wr(8'h56, 16'he001);
    wirq(0, gap);
    wirq(0, gap);
    check("t0 period", 16'd20, gap[15:0]);
    @(posedge clk_i);
    check("tout low", 16'h0000, {15'h0000, tout_o[0]});
    @(posedge clk_i);
    check("tout high", 16'h0001, {15'h0000, tout_o[0]});
    wb(1'b0, 8'h50, 16'h0000, 2'h3);
    check("count range", 16'h0001, {15'h0000, rd < 16'h0005});
    rchk("t0 control", 8'h56, 16'ha021);
    $display("Done single compare");
    wr(8'h56, 16'h6000);
    wr(8'h52, 16'h0003);
    wr(8'h50, 16'h0000);
    wr(8'h56, 16'he000);
    wirq(0, gap);
    repeat (20) @(posedge clk_i);
    rchk("t0 halted", 8'h56, 16'h2020);
    rchk("t0 count", 8'h50, 16'h0000);
    hold <= 2'b00;
    wr(8'h56, 16'he001);
    repeat (40) @(posedge clk_i);
    rchk("gated count", 8'h50, 16'h0000);
    wr(8'h56, 16'h4000);
    $display("Done halt and gate");
    wr(8'h5a, 16'h0100);
    wr(8'h58, 16'h0000);
    wr(8'h5e, 16'hc00d);
    burst <= 2'b10;
    repeat (24) @(posedge clk_i);
    burst <= 2'b00;
    repeat (10) @(posedge clk_i);
    rchk("ext count", 8'h58, 16'h0006);
    wr(8'h5e, 16'h4000);
    wr(8'h58, 16'h0000);
    wr(8'h5e, 16'hc011);
    repeat (20) @(posedge clk_i);
    rchk("no trigger", 8'h58, 16'h0000);
    burst <= 2'b10;
    repeat (4) @(posedge clk_i);
    burst <= 2'b00;
    repeat (40) @(posedge clk_i);
    wb(1'b0, 8'h58, 16'h0000, 2'h3);
    check("started", 16'h0001, {15'h0000, rd >= 16'h0004});
    burst <= 2'b10;
    repeat (4) @(posedge clk_i);
    burst <= 2'b00;
    wb(1'b0, 8'h58, 16'h0000, 2'h3);
    check("retrigger", 16'h0001, {15'h0000, rd < 16'h0004});
    wr(8'h5e, 16'h4000);
    $display("Done timer 1");
    wr(8'h62, 16'h0002);
    wr(8'h66, 16'hffff);
    rchk("t2 control", 8'h66, 16'ha021);
    wirq(2, gap);
    wirq(2, gap);
    check("t2 period", 16'd8, gap[15:0]);
    hold <= 2'b10;
    wr(8'h58, 16'h0000);
    wr(8'h5e, 16'hc009);
    repeat (80) @(posedge clk_i);
    wb(1'b0, 8'h58, 16'h0000, 2'h3);
    check("prescaled", 16'h0001, {15'h0000, rd >= 16'h0008 && rd <= 16'h000b});
    wr(8'h5e, 16'h4000);
    wr(8'h66, 16'h4000);
    $display("Done timer 2");
    hold <= 2'b01;
    wr(8'h52, 16'h0003);
    wr(8'h54, 16'h0002);
    wr(8'h50, 16'h0000);
    wr(8'h56, 16'he003);
    wirq(0, gap);
    wirq(0, gap);
    check("B period", 16'd8, gap[15:0]);
    wirq(0, gap);
    check("A period", 16'd12, gap[15:0]);
    repeat (2) @(posedge clk_i);
    check("tout on B", 16'h0000, {15'h0000, tout_o[0]});
    $display("Done dual compare");
    report_and_stop;
  end
endmodule // ttu_top_tb
